// >>> rtl/adc_pkg.sv
// Purpose: Shared constants and types for the converter register block.
// Assumes: 32-bit AXI4-Lite, one aligned word per register.
// Notes:   Registers hold up to 8 bits in the low byte; upper bits read zero.
package adc_pkg;
  localparam logic [7:0] OFS_RES_HI  = 8'h00;
  localparam logic [7:0] OFS_RES_LO  = 8'h04;
  localparam logic [7:0] OFS_CMP_HI  = 8'h08;
  localparam logic [7:0] OFS_CMP_LO  = 8'h0C;
  localparam logic [7:0] OFS_CFG     = 8'h10;
  localparam logic [7:0] OFS_PINSEL  = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_CMPCTL  = 8'h1C;

  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam int         FLAG_BIT    = 7;
  localparam int         CMP_EN_BIT  = 5;
  localparam int         CMP_GT_BIT  = 4;

  localparam logic [1:0] MODE_8      = 2'h0;
  localparam logic [1:0] MODE_12     = 2'h1;
  localparam logic [1:0] MODE_10     = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       low_power_select;
    logic [1:0] clock_divide_select;
    logic       long_sample_select;
    logic [1:0] conversion_mode;
    logic [1:0] input_clock_select;
  } cfg_t;
endpackage

// >>> rtl/adc_result_compare_config.sv
// Purpose: Result, compare, configuration and pin control registers.
// Assumes: conv_done and conv_data come from the converter on clk.
// Notes:   pin_in is asynchronous and passes a three-stage synchroniser.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module adc_result_compare_config #(
  parameter int PINS = 8
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              conv_done,
  input  wire logic [11:0]       conv_data,
  output adc_pkg::cfg_t          converter_config,
  output logic                   compare_enable,
  output logic                   compare_greater_select,
  output logic                   conversion_complete_flag,
  input  wire logic [PINS-1:0]   port_out,
  input  wire logic [PINS-1:0]   port_oe,
  input  wire logic [PINS-1:0]   port_pullup,
  input  wire logic [PINS-1:0]   pin_in,
  output logic [PINS-1:0]        pin_out,
  output logic [PINS-1:0]        pin_oe,
  output logic [PINS-1:0]        pin_pullup_en,
  output logic [PINS-1:0]        port_read
);
  logic [7:0]      aw_addr_reg;
  logic            aw_have_reg;
  logic [7:0]      w_data_reg;
  logic            w_strb0_reg;
  logic            w_have_reg;
  logic [3:0]      res_hi_reg;
  logic [7:0]      res_lo_reg;
  logic [3:0]      cmp_hi_reg;
  logic [7:0]      cmp_lo_reg;
  logic [PINS-1:0] pin_sel_reg;
  logic            lock_reg;
  logic [PINS-1:0] sync1_reg;
  logic [PINS-1:0] sync2_reg;
  logic [PINS-1:0] sync3_reg;
  logic [PINS-1:0] pin_stable_reg;
  logic            wr_do;
  logic            rd_do;
  logic            rd_hi;
  logic            rd_lo;
  logic            st_wr;
  logic            lock_eff;
  logic [11:0]     res_m;
  logic [11:0]     cmp_m;
  logic            cmp_true;
  logic [11:0]     diff;
  logic [11:0]     store;
  logic            accept;
  logic            upd;
  logic [7:0]      rd_mux;
  logic            rd_ok;
  logic            is8;

  assign is8      = converter_config.conversion_mode == adc_pkg::MODE_8;
  assign wr_do    = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign rd_do    = s_axi_arvalid && s_axi_arready;
  assign rd_hi    = rd_do && s_axi_araddr == adc_pkg::OFS_RES_HI;
  assign rd_lo    = rd_do && s_axi_araddr == adc_pkg::OFS_RES_LO;
  assign st_wr    = wr_do && aw_addr_reg == adc_pkg::OFS_STATUS;
  assign lock_eff = lock_reg && !is8;

  // Mask the raw result and compare value to the selected width.
  always_comb begin
    case (converter_config.conversion_mode)
      adc_pkg::MODE_8: begin
        res_m = {4'h0, conv_data[7:0]};
        cmp_m = {4'h0, cmp_lo_reg};
      end
      adc_pkg::MODE_10: begin
        res_m = {2'h0, conv_data[9:0]};
        cmp_m = {2'h0, cmp_hi_reg[1:0], cmp_lo_reg};
      end
      default: begin
        res_m = conv_data;
        cmp_m = {cmp_hi_reg, cmp_lo_reg};
      end
    endcase
  end

  assign cmp_true = compare_greater_select ? (res_m >= cmp_m) : (res_m < cmp_m);
  assign diff     = res_m + ~cmp_m + 12'h001;
  assign accept   = conv_done && (!compare_enable || cmp_true);
  // A result high read in the same cycle, outside 8-bit mode, blocks the update so the pair stays coherent.
  assign upd      = accept && !lock_eff && !(rd_hi && !is8);

  always_comb begin
    store = compare_enable ? diff : res_m;
    case (converter_config.conversion_mode)
      adc_pkg::MODE_8:  store[11:8]  = 4'h0;
      adc_pkg::MODE_10: store[11:10] = 2'h0;
      default:          store[11:8]  = store[11:8];
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      res_hi_reg <= 4'h0;
      res_lo_reg <= adc_pkg::RST_BYTE;
    end else if (upd) begin
      res_hi_reg <= store[11:8];
      res_lo_reg <= store[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      lock_reg <= 1'b0;
    end else if (rd_lo) begin
      lock_reg <= 1'b0;
    end else if (rd_hi && !is8) begin
      lock_reg <= 1'b1;
    end
  end

  // Setting wins over clearing so no completion is lost.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      conversion_complete_flag <= 1'b0;
    end else if (accept) begin
      conversion_complete_flag <= 1'b1;
    end else if (rd_lo || st_wr) begin
      conversion_complete_flag <= 1'b0;
    end
  end

  // Write address and data channels, taken in either order.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_have_reg   <= 1'b0;
      aw_addr_reg   <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg   <= 1'b1;
      aw_addr_reg   <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_do) begin
      aw_have_reg   <= 1'b0;
    end else if (!aw_have_reg && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      w_have_reg   <= 1'b0;
      w_data_reg   <= 8'h00;
      w_strb0_reg  <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg   <= 1'b1;
      w_data_reg   <= s_axi_wdata[7:0];
      w_strb0_reg  <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (wr_do) begin
      w_have_reg   <= 1'b0;
    end else if (!w_have_reg && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= adc_pkg::RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_reg > adc_pkg::OFS_CMPCTL || aw_addr_reg[1:0] != 2'h0) ?
                      adc_pkg::RESP_SLVERR : adc_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Writable registers; result and status words ignore write data.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmp_hi_reg             <= 4'h0;
      cmp_lo_reg             <= adc_pkg::RST_BYTE;
      converter_config       <= adc_pkg::cfg_t'(adc_pkg::RST_BYTE);
      pin_sel_reg            <= '0;
      compare_enable         <= 1'b0;
      compare_greater_select <= 1'b0;
    end else if (wr_do && w_strb0_reg) begin
      case (aw_addr_reg)
        adc_pkg::OFS_CMP_HI: cmp_hi_reg <= w_data_reg[3:0];
        adc_pkg::OFS_CMP_LO: cmp_lo_reg <= w_data_reg;
        adc_pkg::OFS_CFG: begin
          converter_config <= adc_pkg::cfg_t'(w_data_reg);
        end
        adc_pkg::OFS_PINSEL: pin_sel_reg <= w_data_reg[PINS-1:0];
        adc_pkg::OFS_CMPCTL: begin
          compare_enable         <= w_data_reg[adc_pkg::CMP_EN_BIT];
          compare_greater_select <= w_data_reg[adc_pkg::CMP_GT_BIT];
        end
        default: cmp_lo_reg <= cmp_lo_reg;
      endcase
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      adc_pkg::OFS_RES_HI: rd_mux = {4'h0, res_hi_reg};
      adc_pkg::OFS_RES_LO: rd_mux = res_lo_reg;
      adc_pkg::OFS_CMP_HI: rd_mux = {4'h0, cmp_hi_reg};
      adc_pkg::OFS_CMP_LO: rd_mux = cmp_lo_reg;
      adc_pkg::OFS_CFG:    rd_mux = converter_config;
      adc_pkg::OFS_PINSEL: rd_mux = pin_sel_reg;
      adc_pkg::OFS_STATUS: rd_mux[adc_pkg::FLAG_BIT] = conversion_complete_flag;
      adc_pkg::OFS_CMPCTL: begin
        rd_mux[adc_pkg::CMP_EN_BIT] = compare_enable;
        rd_mux[adc_pkg::CMP_GT_BIT] = compare_greater_select;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= adc_pkg::RESP_OKAY;
    end else if (rd_do) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_mux};
      s_axi_rresp   <= rd_ok ? adc_pkg::RESP_OKAY : adc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Pin synchroniser; a level counts once stages two and three agree.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_reg      <= '0;
      sync2_reg      <= '0;
      sync3_reg      <= '0;
      pin_stable_reg <= '0;
    end else begin
      sync1_reg      <= pin_in;
      sync2_reg      <= sync1_reg;
      sync3_reg      <= sync2_reg;
      pin_stable_reg <= (sync2_reg & sync3_reg) | (pin_stable_reg & (sync2_reg ^ sync3_reg));
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_out       <= '0;
      pin_oe        <= '0;
      pin_pullup_en <= '0;
      port_read     <= '0;
    end else begin
      pin_out       <= port_out & ~pin_sel_reg;
      pin_oe        <= port_oe & ~pin_sel_reg;
      pin_pullup_en <= port_pullup & ~pin_sel_reg;
      port_read     <= pin_stable_reg & ~pin_sel_reg;
    end
  end

  mode8_hi_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    upd && is8 |=> res_hi_reg == 4'h0)
    else $error("result high not zero in 8-bit mode");

  mode10_top_a: assert property (@(posedge clk) disable iff (!resetn)
    upd && converter_config.conversion_mode == adc_pkg::MODE_10 |=> res_hi_reg[3:2] == 2'h0)
    else $error("result bits 11:10 not zero in 10-bit mode");

  locked_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    conv_done && lock_eff |=> $stable(res_lo_reg) && $stable(res_hi_reg))
    else $error("locked result changed");

  cmp_false_a: assert property (@(posedge clk) disable iff (!resetn)
    conv_done && compare_enable && !cmp_true |=> $stable(res_lo_reg) && !$rose(conversion_complete_flag))
    else $error("failed compare updated result");

  cmp_diff_a: assert property (@(posedge clk) disable iff (!resetn)
    upd && compare_enable && is8 |=> res_lo_reg == $past(conv_data[7:0] - cmp_lo_reg))
    else $error("compare difference wrong");

  mode8_free_a: assert property (@(posedge clk) disable iff (!resetn)
    conv_done && is8 && !compare_enable ##0 is8 |=> res_lo_reg == $past(conv_data[7:0]))
    else $error("8-bit result not stored");

  hi_lock_a: assert property (@(posedge clk) disable iff (!resetn)
    rd_hi && !is8 |=> lock_reg ##1 (lock_reg || $past(rd_lo)))
    else $error("result high read did not lock");

  flag_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    (rd_lo || st_wr) && !accept |=> !conversion_complete_flag)
    else $error("complete flag not cleared");

  flag_set_a: assert property (@(posedge clk) disable iff (!resetn)
    accept |=> conversion_complete_flag)
    else $error("complete flag not set");

  pin_off_a: assert property (@(posedge clk) disable iff (!resetn)
    pin_sel_reg[0] |=> !pin_oe[0] && !pin_pullup_en[0] && !port_read[0])
    else $error("selected pin still under port control");

  lo_unlock_a: assert property (@(posedge clk) disable iff (!resetn)
    rd_lo |=> !lock_reg)
    else $error("result low read did not unlock");

  hi_store_a: assert property (@(posedge clk) disable iff (!resetn)
    upd && !compare_enable && converter_config.conversion_mode == adc_pkg::MODE_12 |=>
    res_hi_reg == $past(conv_data[11:8]))
    else $error("12-bit result high wrong");

  lo_store_a: assert property (@(posedge clk) disable iff (!resetn)
    upd && !compare_enable |=> res_lo_reg == $past(conv_data[7:0]))
    else $error("result low does not hold low result bits");

  rdata_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("unused read data bits not zero");

  cfg_write_a: assert property (@(posedge clk) disable iff (!resetn)
    wr_do && w_strb0_reg && aw_addr_reg == adc_pkg::OFS_CFG |=>
    converter_config == adc_pkg::cfg_t'($past(w_data_reg)))
    else $error("configuration write not stored");

  pinsel_write_a: assert property (@(posedge clk) disable iff (!resetn)
    wr_do && w_strb0_reg && aw_addr_reg == adc_pkg::OFS_PINSEL |=> pin_sel_reg == $past(w_data_reg[PINS-1:0]))
    else $error("pin select write not stored");

  cmp8_low_a: assert property (@(posedge clk) disable iff (!resetn)
    conv_done && is8 && compare_enable && !compare_greater_select && conv_data[7:0] >= cmp_lo_reg |=>
    $stable(res_lo_reg))
    else $error("8-bit compare on low bits wrong");
endmodule

// >>> test/adc_result_compare_config_test.sv
// Purpose: Self-checking bench for the converter result, compare and config registers.
// Assumes: AXI4-Lite timing as handed over; conversions are fed as one-cycle pulses.
// Notes:   Expected values are worked out here from the register behaviour, not read back.
`timescale 1ns/1ps
module adc_result_compare_config_test;
  localparam logic [7:0] RH = adc_pkg::OFS_RES_HI;
  localparam logic [7:0] RL = adc_pkg::OFS_RES_LO;
  localparam logic [7:0] CH = adc_pkg::OFS_CMP_HI;
  localparam logic [7:0] CL = adc_pkg::OFS_CMP_LO;
  localparam logic [7:0] CF = adc_pkg::OFS_CFG;
  localparam logic [7:0] PS = adc_pkg::OFS_PINSEL;
  localparam logic [7:0] ST = adc_pkg::OFS_STATUS;
  localparam logic [7:0] CC = adc_pkg::OFS_CMPCTL;
  logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, conv_done, bvalid, rvalid, awready, wready, arready;
  logic [7:0] awaddr, araddr, port_out, port_oe, port_pullup, pin_in, pin_out, pin_oe, pin_pullup_en, port_read;
  logic [31:0] wdata, rdata, rd_word;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, last_bresp, last_rresp;
  logic [11:0] conv_data;
  logic cmp_en, cmp_gt, flag;
  adc_pkg::cfg_t cfg;
  int n_errors, total_checks;

  adc_result_compare_config i_adc_result_compare_config (
    .clk(clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conv_done(conv_done), .conv_data(conv_data), .converter_config(cfg),
    .compare_enable(cmp_en), .compare_greater_select(cmp_gt), .conversion_complete_flag(flag),
    .port_out(port_out), .port_oe(port_oe), .port_pullup(port_pullup), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .port_read(port_read)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= {24'h000000, d}; wstrb <= 4'hF; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clk);
    last_bresp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rd_word = rdata;
    last_rresp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rd_word, {24'h000000, e});
    chk({30'h0, last_rresp}, {30'h0, adc_pkg::RESP_OKAY});
  endtask

  // One completion pulse, then one idle cycle so the result lands before the next access.
  task automatic conv(input logic [11:0] d);
    @(posedge clk);
    conv_done <= 1'b1; conv_data <= d;
    @(posedge clk);
    conv_done <= 1'b0;
    @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish;
  end

  initial begin
    logic [7:0] v;
    resetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h00000000; wstrb = 4'h0; conv_done = 1'b0; conv_data = 12'h000;
    port_out = 8'hFF; port_oe = 8'hFF; port_pullup = 8'hFF; pin_in = 8'hFF;
    n_errors = 0; total_checks = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 6; i++) rchk(8'(4 * i), 8'h00);
    chk({24'h0, cfg}, 32'h00000000);
    for (int i = 0; i < 9; i++) begin
      v = (i == 8) ? 8'hFF : 8'(1 << i);
      wr(CF, v);
      chk({24'h0, cfg}, {24'h0, v});
      rchk(CF, v);
    end
    wr(CF, 8'h04); conv(12'hABC);
    rchk(RH, 8'h0A);
    rchk(RL, 8'hBC);
    wr(CF, 8'h08); conv(12'hFFF);
    rchk(RH, 8'h03);
    rchk(RL, 8'hFF);
    wr(CF, 8'h00); conv(12'h5A3);
    rchk(RH, 8'h00);
    rchk(RL, 8'hA3);
    for (int m = 0; m < 2; m++) begin
      wr(CF, (m == 0) ? 8'h04 : 8'h08); conv(12'h111);
      rchk(RH, 8'h01);
      conv(12'h222);
      rchk(RL, 8'h11);
      conv(12'h333);
      rchk(RH, 8'h03);
      rchk(RL, 8'h33);
    end
    wr(CF, 8'h00); conv(12'h011);
    rchk(RH, 8'h00); conv(12'h022);
    rchk(RL, 8'h22);
    conv(12'h033);
    chk({31'h0, flag}, 32'h00000001);
    wr(ST, 8'h00);
    chk({31'h0, flag}, 32'h00000000);
    conv(12'h044);
    rchk(RL, 8'h44);
    chk({31'h0, flag}, 32'h00000000);
    wr(CF, 8'h04); conv(12'hABC);
    rchk(RH, 8'h0A); rchk(RL, 8'hBC);
    wr(CH, 8'hFF);
    rchk(CH, 8'h0F);
    wr(CH, 8'h01); wr(CL, 8'h00); wr(CC, 8'h20);
    chk({30'h0, cmp_en, cmp_gt}, 32'h00000002);
    conv(12'h200);
    chk({31'h0, flag}, 32'h00000000);
    rchk(RH, 8'h0A);
    rchk(RL, 8'hBC);
    conv(12'h080);
    rchk(RH, 8'h0F);
    rchk(RL, 8'h80);
    wr(CC, 8'h30);
    chk({30'h0, cmp_en, cmp_gt}, 32'h00000003);
    conv(12'h0FF);
    rchk(RH, 8'h0F); rchk(RL, 8'h80);
    conv(12'h1A5);
    rchk(RH, 8'h00); rchk(RL, 8'hA5);
    wr(CF, 8'h08); wr(CH, 8'h05); conv(12'h180);
    rchk(RH, 8'h00); rchk(RL, 8'h80);
    wr(CF, 8'h00); conv(12'h050);
    rchk(RL, 8'h50);
    wr(CL, 8'h70); wr(CC, 8'h20); conv(12'h060);
    rchk(RL, 8'hF0);
    conv(12'h075);
    rchk(RL, 8'hF0);
    wr(CC, 8'h00);
    wr(PS, 8'h0F);
    repeat (8) @(posedge clk);
    chk({pin_oe, pin_out, pin_pullup_en, port_read}, 32'hF0F0F0F0);
    rchk(PS, 8'h0F);
    pin_in <= 8'h5A;
    repeat (3) @(posedge clk);
    chk({24'h0, port_read}, 32'h000000F0);
    repeat (5) @(posedge clk);
    chk({24'h0, port_read}, 32'h00000050);
    wr(8'h20, 8'h11);
    chk({30'h0, last_bresp}, {30'h0, adc_pkg::RESP_SLVERR});
    rd(8'h20);
    chk({30'h0, last_rresp}, {30'h0, adc_pkg::RESP_SLVERR});
    chk(rd_word, 32'h00000000);
    wr(8'h09, 8'h11);
    chk({30'h0, last_bresp}, {30'h0, adc_pkg::RESP_SLVERR});
    wr(RL, 8'h55);
    rchk(RL, 8'hF0);
    wr(CF, 8'h0C);
    conv(12'h7E5);
    rchk(RH, 8'h07);
    rchk(RL, 8'hE5);
    tally_and_finish;
  end
endmodule
